// File: hw/ocs_defs.vh
`ifndef OCS_DEFS_VH
`define OCS_DEFS_VH

// Register byte offsets
`define OCS_CTRL 12'h000
`define OCS_UNLOCK 12'h004
`define OCS_SCALE 12'h008
`define OCS_STATUS 12'h00c
`define OCS_FORCE_STATE 12'h010
`define OCS_CNT_CLR 12'h014
`define OCS_CT_RATIO 12'h018
`define OCS_LMAX 12'h01c
`define OCS_LOAD 12'h020
`define OCS_CNT_BASE 12'h040
`define OCS_PRIM_BASE 12'h060
`define OCS_SET_BASE 12'h100
`define OCS_LOG_BASE 12'h200

// Control register fields
`define OCS_CTRL_FORCE 0
`define OCS_CTRL_SCALE 1
`define OCS_CTRL_MGRP 2
`define OCS_CTRL_AGRP 4
`define OCS_CTRL_SRCK 6
`define OCS_CTRL_SRCI 9
`define OCS_CTRL_W 12

// Group select source kinds
`define OCS_SRC_NONE 3'h0
`define OCS_SRC_DIN 3'h1
`define OCS_SRC_VIN 3'h2
`define OCS_SRC_LAMP 3'h3
`define OCS_SRC_VOUT 3'h4

// Stage status codes
`define OCS_ST_IDLE 2'h0
`define OCS_ST_BLOCKED 2'h1
`define OCS_ST_STARTED 2'h2
`define OCS_ST_TRIPPED 2'h3

// Fault type codes
`define OCS_FT_1N 3'h1
`define OCS_FT_2N 3'h2
`define OCS_FT_3N 3'h3
`define OCS_FT_12 3'h4
`define OCS_FT_23 3'h5
`define OCS_FT_31 3'h6
`define OCS_FT_123 3'h7

// Reset values and limits
`define OCS_SCALE_RST 8'h64
`define OCS_SCALE_MIN 8'h0a
`define OCS_SCALE_MAX 8'hc8
`define OCS_SCALE_UNITY 8'h64
`define OCS_CT_RST 16'h0100
`define OCS_PICKUP_RST 16'h0100
`define OCS_DELAY_RST 24'h000064
`define OCS_EDLY_TRIP 8'h64

// Timing
`define OCS_CLK_HZ 100000000
`define OCS_TICK_US 1000
`define OCS_MS_CYC (`OCS_TICK_US * (`OCS_CLK_HZ / 1000000))
`define OCS_FORCE_MIN 5
`define OCS_FORCE_MS (`OCS_FORCE_MIN * 60 * 1000)
`define OCS_LOAD_WIN_MS 1000

`endif

// File: hw/ocs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ocs_defs.vh"

// What this block does
// R1 - Stage status idle, blocked, started, tripped; start and trip writable only under force
// R2 - One shared force flag, cleared automatically five minutes after it is set or after the last accepted bus write
// R3 - Per stage start and trip event counters, each clearable to zero
// R4 - Editable settings change only after the password unlocks them
// R5 - One of four groups active, optionally chosen by a configured signal source
// R6 - Largest of three phase currents is compared against each pick-up
// R7 - Pick-up shown as relative setting and as primary amperes
// R8 - Eight latest fault records with stamp, type, currents, delay and group
// R9 - Records stamped with date and millisecond time of day
// R10 - Fault type coded as ground, two phase or three phase
// R11 - Pre-fault load is the one second average before the fault
// R12 - Elapsed delay recorded as percent of operate time, hundred meaning trip
// R13 - Scaling is unity when off, else one value from ten to two hundred
// R14 - With scaling on, group two is group one with scaled pick-ups
// R15 - Enabling scaling moves the active group from one to two
// R16 - Scaling factor is an integer, one count per percent
// R17 - While scaling, group two is owned by it and group switching is held
// R18 - Scaling is enabled, disabled and adjusted through the register bus
// R19 - Start when current exceeds pick-up, trip when that outlasts the delay
// R20 - Counters step on entering started or tripped; each cycle with a new trip writes one record
module ocs_top #(
  parameter NS = 3,
  parameter CUR_W = 16,
  parameter MS_CYC = `OCS_MS_CYC,
  parameter FORCE_MS = `OCS_FORCE_MS,
  parameter [31:0] PASS_KEY = 32'h5a5a_1234  // Arbitrary unlock key
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Measurement and plant signals
  input wire [CUR_W-1:0] phase_a_current,
  input wire [CUR_W-1:0] phase_b_current,
  input wire [CUR_W-1:0] phase_c_current,
  input wire earth_fault,
  input wire [NS-1:0] stage_block,
  input wire [7:0] digital_in,
  input wire [7:0] virtual_input_n,
  input wire [7:0] indicator_lamp_n,
  input wire [7:0] virtual_output_n,
  input wire [31:0] rtc_date,
  input wire [31:0] rtc_time_ms,
  // Stage outputs
  output reg [NS-1:0] stage_start,
  output reg [NS-1:0] stage_trip,
  output reg [1:0] active_group_index,
  output reg force_active
);

  localparam NG = 4;
  localparam NL = 8;

  function [2:0] fault_code;
    input a, b, c, e;
    begin
      case ({a, b, c})
        3'b111: fault_code = `OCS_FT_123;
        3'b110: fault_code = `OCS_FT_12;
        3'b011: fault_code = `OCS_FT_23;
        3'b101: fault_code = `OCS_FT_31;
        3'b010: fault_code = `OCS_FT_2N;
        3'b001: fault_code = `OCS_FT_3N;
        default: fault_code = e ? `OCS_FT_1N : 3'h0;
      endcase
    end
  endfunction

  function [7:0] pick8;
    input [7:0] v;
    input [2:0] i;
    begin
      pick8 = {7'h00, v[i]};
    end
  endfunction

  // Configuration state
  reg [`OCS_CTRL_W-1:0] ctrl;
  reg unlocked;
  reg [7:0] scale_pct;
  reg [15:0] ct_ratio;
  reg [NS*2-1:0] forced_state;
  // Four slots per group so group rows start on a power of two
  reg [CUR_W-1:0] pickup_mem [0:NG*4-1];
  reg [23:0] delay_mem [0:NG*4-1];

  // Stage state
  reg [1:0] stage_state [0:NS-1];
  reg [23:0] elapsed [0:NS-1];
  reg [31:0] start_event_count [0:NS-1];
  reg [31:0] trip_event_count [0:NS-1];

  // Fault log, slot head-1 holds the newest record
  reg [31:0] log_date [0:NL-1];
  reg [31:0] log_time [0:NL-1];
  reg [2:0] log_type [0:NL-1];
  reg [CUR_W-1:0] log_flt [0:NL-1];
  reg [CUR_W-1:0] log_load [0:NL-1];
  reg [7:0] log_edly [0:NL-1];
  reg [1:0] log_grp [0:NL-1];
  reg [2:0] log_head;

  // Timebase and load averaging
  reg [31:0] ms_cnt;
  reg ms_tick;
  reg [31:0] force_cnt;
  reg [9:0] load_n;
  reg [CUR_W+9:0] load_sum;
  reg [CUR_W-1:0] load_avg;

  wire force_flag = ctrl[`OCS_CTRL_FORCE];
  wire scale_en = ctrl[`OCS_CTRL_SCALE];
  wire [2:0] src_kind = ctrl[`OCS_CTRL_SRCK+2:`OCS_CTRL_SRCK];
  wire [2:0] src_idx = ctrl[`OCS_CTRL_SRCI+2:`OCS_CTRL_SRCI];

  // Largest phase current
  wire [CUR_W-1:0] ab_max = (phase_a_current > phase_b_current) ? phase_a_current : phase_b_current;
  wire [CUR_W-1:0] largest_phase_current = (ab_max > phase_c_current) ? ab_max : phase_c_current; // R6
  localparam [CUR_W+9:0] LOAD_WIN = `OCS_LOAD_WIN_MS;
  wire [CUR_W+9:0] load_mean = (load_sum + largest_phase_current) / LOAD_WIN;

  // Group selection
  reg [7:0] src_level;
  reg [1:0] next_group;
  always @* begin
    case (src_kind) // R5
      `OCS_SRC_DIN: src_level = pick8(digital_in, src_idx);
      `OCS_SRC_VIN: src_level = pick8(virtual_input_n, src_idx);
      `OCS_SRC_LAMP: src_level = pick8(indicator_lamp_n, src_idx);
      `OCS_SRC_VOUT: src_level = pick8(virtual_output_n, src_idx);
      default: src_level = 8'h00;
    endcase
    if (scale_en) begin
      next_group = 2'h1; // R15 R17
    end else if (src_level[0]) begin
      next_group = ctrl[`OCS_CTRL_AGRP+1:`OCS_CTRL_AGRP]; // R5
    end else begin
      next_group = ctrl[`OCS_CTRL_MGRP+1:`OCS_CTRL_MGRP];
    end
  end

  // Effective per stage settings and next status
  wire [CUR_W-1:0] pickup_eff [0:NS-1];
  wire [23:0] delay_eff [0:NS-1];
  wire [23:0] prim_pickup [0:NS-1];
  wire [CUR_W-1:0] scaled_pick [0:NS-1];
  wire [NS-1:0] over;
  wire [1:0] next_state [0:NS-1];
  genvar s;
  generate
    for (s = 0; s < NS; s = s + 1) begin : g_stage
      wire [CUR_W+7:0] prod = pickup_mem[s] * scale_pct; // R16
      wire [CUR_W+7:0] quot = prod / 8'h64;
      wire [CUR_W-1:0] scaled = (|quot[CUR_W+7:CUR_W]) ? {CUR_W{1'b1}} : quot[CUR_W-1:0];
      wire [CUR_W+15:0] prim = pickup_eff[s] * ct_ratio;
      wire [1:0] natural;
      assign scaled_pick[s] = scaled;
      // With scaling on, group two is derived, not read from its slots, so it can never drift from group one
      assign pickup_eff[s] = (scale_en && active_group_index == 2'h1) ? scaled : // R14
        pickup_mem[{active_group_index, 2'h0} + s];
      assign delay_eff[s] = (scale_en && active_group_index == 2'h1) ? delay_mem[s] : // R14
        delay_mem[{active_group_index, 2'h0} + s];
      assign prim_pickup[s] = prim[31:8]; // R7
      assign over[s] = largest_phase_current > pickup_eff[s]; // R19
      assign natural = stage_block[s] ? `OCS_ST_BLOCKED :
        (over[s] && elapsed[s] >= delay_eff[s]) ? `OCS_ST_TRIPPED : // R19
        over[s] ? `OCS_ST_STARTED : `OCS_ST_IDLE;
      assign next_state[s] = (force_flag && forced_state[2*s+1]) ? // R1
        forced_state[2*s+1:2*s] : natural;
    end
  endgenerate

  // First stage entering trip this cycle
  reg trip_event;
  reg [2:0] trip_code;
  integer k;
  always @* begin
    trip_event = 1'b0;
    trip_code = 3'h0;
    for (k = NS - 1; k >= 0; k = k - 1) begin
      if (next_state[k] == `OCS_ST_TRIPPED && stage_state[k] != `OCS_ST_TRIPPED) begin
        trip_event = 1'b1; // R20
        trip_code = fault_code(phase_a_current > pickup_eff[k],
          phase_b_current > pickup_eff[k], phase_c_current > pickup_eff[k], earth_fault); // R10
      end
    end
  end

  // Bus decode
  wire [11:0] a = paddr;
  wire in_set = a[11:8] == 4'h1 && a[4:2] < 3'h6;
  wire [3:0] set_idx = {a[6:5], 2'h0} + {2'h0, a[4:3]};
  wire in_log = a[11:8] == 4'h2 && a[4:2] < 3'h7;
  wire [2:0] log_idx = log_head - 3'h1 - a[7:5];
  wire in_cnt = a[11:5] == 7'h02 && a[4:3] < NS;
  wire in_prim = a[11:4] == 8'h06 && a[3:2] < NS;
  wire setting_wr = a == `OCS_CTRL || a == `OCS_SCALE || a == `OCS_CT_RATIO || in_set;

  reg [31:0] rd_val;
  reg hit;
  reg refuse;
  always @* begin
    rd_val = 32'h0;
    hit = 1'b1;
    refuse = 1'b0;
    if (in_set) begin
      rd_val = a[2] ? {8'h00, delay_mem[set_idx]} : {16'h0, pickup_mem[set_idx]};
      if (scale_en && a[6:5] == 2'h1) begin
        rd_val = a[2] ? {8'h00, delay_mem[{2'h0, a[4:3]}]} : {16'h0, scaled_pick[a[4:3]]}; // R14
      end
      refuse = pwrite && scale_en && a[6:5] == 2'h1; // R17
    end else if (in_log) begin
      case (a[4:2])
        3'h0: rd_val = log_date[log_idx];
        3'h1: rd_val = log_time[log_idx];
        3'h2: rd_val = {29'h0, log_type[log_idx]};
        3'h3: rd_val = {16'h0, log_flt[log_idx]};
        3'h4: rd_val = {16'h0, log_load[log_idx]};
        3'h5: rd_val = {24'h0, log_edly[log_idx]};
        default: rd_val = {30'h0, log_grp[log_idx]} + 32'h1;
      endcase
    end else if (in_cnt) begin
      rd_val = a[2] ? trip_event_count[a[4:3]] : start_event_count[a[4:3]];
    end else if (in_prim) begin
      rd_val = {8'h00, prim_pickup[a[3:2]]};
    end else begin
      case (a)
        `OCS_CTRL: rd_val = {20'h0, ctrl};
        `OCS_UNLOCK: rd_val = {31'h0, unlocked};
        `OCS_SCALE: rd_val = {24'h0, scale_pct};
        `OCS_STATUS: rd_val = {24'h0, forced_state[1:0], unlocked, force_flag,
          scale_en, 1'b0, active_group_index};
        `OCS_FORCE_STATE: rd_val = {26'h0, forced_state};
        `OCS_CNT_CLR: rd_val = 32'h0;
        `OCS_CT_RATIO: rd_val = {16'h0, ct_ratio};
        `OCS_LMAX: rd_val = {16'h0, largest_phase_current};
        `OCS_LOAD: rd_val = {16'h0, load_avg};
        default: hit = 1'b0;
      endcase
      if (a == `OCS_STATUS) begin
        rd_val[15:8] = {stage_state[2], stage_state[1], stage_state[0], 2'h0};
      end
    end
    if (pwrite && setting_wr && !unlocked) begin
      refuse = 1'b1; // R4
    end
    if (pwrite && a == `OCS_FORCE_STATE && !force_flag) begin
      refuse = 1'b1; // R1
    end
  end

  wire wr_ok = psel && penable && pready && pwrite && hit && !refuse;

  // APB answer one cycle into the access phase
  always @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && (!hit || refuse);
      prdata <= (psel && penable && !pready && !pwrite && hit) ? rd_val : 32'h0;
    end
  end

  // Millisecond tick, force timeout and load average
  always @(posedge ref_clk) begin
    if (rst) begin
      ms_cnt <= 32'h0;
      ms_tick <= 1'b0;
      force_cnt <= 32'h0;
      load_n <= 10'h0;
      load_sum <= {(CUR_W+10){1'b0}};
      load_avg <= {CUR_W{1'b0}};
    end else begin
      ms_tick <= ms_cnt == MS_CYC - 1;
      ms_cnt <= (ms_cnt == MS_CYC - 1) ? 32'h0 : ms_cnt + 32'h1;
      if (!force_flag || wr_ok) begin
        force_cnt <= 32'h0; // R2
      end else if (ms_tick) begin
        force_cnt <= force_cnt + 32'h1;
      end
      if (ms_tick) begin
        // Block average: the value holds the last complete second before the fault
        if (load_n == `OCS_LOAD_WIN_MS - 1) begin
          load_n <= 10'h0;
          load_sum <= {(CUR_W+10){1'b0}};
          load_avg <= load_mean[CUR_W-1:0]; // R11
        end else begin
          load_n <= load_n + 10'h1;
          load_sum <= load_sum + largest_phase_current;
        end
      end
    end
  end

  // Configuration writes
  integer i;
  integer j;
  integer m;
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= {`OCS_CTRL_W{1'b0}};
      unlocked <= 1'b0;
      scale_pct <= `OCS_SCALE_RST;
      ct_ratio <= `OCS_CT_RST;
      forced_state <= {(2*NS){1'b0}};
      for (i = 0; i < NG * 4; i = i + 1) begin
        pickup_mem[i] <= `OCS_PICKUP_RST;
        delay_mem[i] <= `OCS_DELAY_RST;
      end
    end else begin
      if (wr_ok && a == `OCS_UNLOCK) begin
        unlocked <= pwdata == PASS_KEY; // R4
      end
      if (wr_ok && a == `OCS_CTRL) begin
        ctrl <= pwdata[`OCS_CTRL_W-1:0]; // R18
      end else if (force_flag && ms_tick && force_cnt >= FORCE_MS - 1) begin
        ctrl[`OCS_CTRL_FORCE] <= 1'b0; // R2
      end
      if (wr_ok && a == `OCS_SCALE) begin
        // Out of range factors are clamped rather than refused
        scale_pct <= (pwdata > {24'h0, `OCS_SCALE_MAX}) ? `OCS_SCALE_MAX : // R13 R16
          (pwdata < {24'h0, `OCS_SCALE_MIN}) ? `OCS_SCALE_MIN : pwdata[7:0];
      end
      if (wr_ok && a == `OCS_CT_RATIO) begin
        ct_ratio <= pwdata[15:0];
      end
      if (!force_flag) begin
        forced_state <= {(2*NS){1'b0}}; // R1
      end else if (wr_ok && a == `OCS_FORCE_STATE) begin
        forced_state <= pwdata[2*NS-1:0]; // R1
      end
      if (wr_ok && in_set && a[2]) begin
        delay_mem[set_idx] <= pwdata[23:0];
      end
      if (wr_ok && in_set && !a[2]) begin
        pickup_mem[set_idx] <= pwdata[CUR_W-1:0];
      end
    end
  end

  // Stage timers, counters and outputs
  always @(posedge ref_clk) begin
    if (rst) begin
      for (j = 0; j < NS; j = j + 1) begin
        stage_state[j] <= `OCS_ST_IDLE;
        elapsed[j] <= 24'h0;
        start_event_count[j] <= 32'h0;
        trip_event_count[j] <= 32'h0;
      end
      stage_start <= {NS{1'b0}};
      stage_trip <= {NS{1'b0}};
      active_group_index <= 2'h0;
      force_active <= 1'b0;
    end else begin
      active_group_index <= next_group; // R5 R15
      force_active <= force_flag;
      for (j = 0; j < NS; j = j + 1) begin
        stage_state[j] <= next_state[j]; // R1
        stage_start[j] <= next_state[j] == `OCS_ST_STARTED || next_state[j] == `OCS_ST_TRIPPED;
        stage_trip[j] <= next_state[j] == `OCS_ST_TRIPPED;
        if (!over[j] || stage_block[j]) begin
          elapsed[j] <= 24'h0;
        end else if (ms_tick && elapsed[j] != 24'hffffff) begin
          elapsed[j] <= elapsed[j] + 24'h1; // R19
        end
        // A clear in the same cycle as an event keeps that event
        if (wr_ok && a == `OCS_CNT_CLR && pwdata[j]) begin
          start_event_count[j] <= {31'h0, next_state[j] == `OCS_ST_STARTED &&
            stage_state[j] != `OCS_ST_STARTED}; // R3
        end else if (next_state[j] == `OCS_ST_STARTED && stage_state[j] != `OCS_ST_STARTED) begin
          start_event_count[j] <= start_event_count[j] + 32'h1; // R20
        end
        if (wr_ok && a == `OCS_CNT_CLR && pwdata[j+8]) begin
          trip_event_count[j] <= {31'h0, next_state[j] == `OCS_ST_TRIPPED &&
            stage_state[j] != `OCS_ST_TRIPPED}; // R3
        end else if (next_state[j] == `OCS_ST_TRIPPED && stage_state[j] != `OCS_ST_TRIPPED) begin
          trip_event_count[j] <= trip_event_count[j] + 32'h1; // R20
        end
      end
    end
  end

  // Fault log, oldest record overwritten
  always @(posedge ref_clk) begin
    if (rst) begin
      log_head <= 3'h0;
      for (m = 0; m < NL; m = m + 1) begin
        log_date[m] <= 32'h0;
        log_time[m] <= 32'h0;
        log_type[m] <= 3'h0;
        log_flt[m] <= {CUR_W{1'b0}};
        log_load[m] <= {CUR_W{1'b0}};
        log_edly[m] <= 8'h0;
        log_grp[m] <= 2'h0;
      end
    end else if (trip_event) begin
      log_head <= log_head + 3'h1; // R8
      log_date[log_head] <= rtc_date; // R9
      log_time[log_head] <= rtc_time_ms; // R9
      log_type[log_head] <= trip_code; // R10
      log_flt[log_head] <= largest_phase_current; // R8
      log_load[log_head] <= load_avg; // R11
      log_edly[log_head] <= `OCS_EDLY_TRIP; // R12
      log_grp[log_head] <= active_group_index; // R8
    end
  end

endmodule // ocs_top

`default_nettype wire

// File: verification/ocs_apb_host.sv
`timescale 1ns/1ps
`default_nettype none
module ocs_apb_host (
  // Clock
  input wire logic ref_clk,
  // Requester side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Completer answers
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Released lines are inverted so a stale address or datum never looks valid
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic to);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    to = pready !== 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // ocs_apb_host
`default_nettype wire

// File: verification/ocs_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocs_defs.vh"
module ocs_checker #(parameter NS = 3, parameter CUR_W = 16, parameter MS_CYC = 10,
  parameter FORCE_MS = 20, parameter [31:0] PASS_KEY = 32'h0) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Plant and outputs
  input wire logic [CUR_W-1:0] phase_a_current,
  input wire logic [CUR_W-1:0] phase_b_current,
  input wire logic [CUR_W-1:0] phase_c_current,
  input wire logic [NS-1:0] stage_block,
  input wire logic [NS-1:0] stage_start,
  input wire logic [NS-1:0] stage_trip,
  input wire logic [1:0] active_group_index,
  input wire logic force_active
);
  // Tick phase is unknown, so one extra tick of slack
  localparam int LIM = FORCE_MS * MS_CYC + MS_CYC + 4;
  logic unl;
  logic scl;
  int fcnt;
  wire wr = psel && penable && pready && pwrite;
  wire ok = wr && !pslverr;
  wire zero = phase_a_current == '0 && phase_b_current == '0 && phase_c_current == '0;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unl <= 1'b0;
      scl <= 1'b0;
      fcnt <= 0;
    end else begin
      if (wr && paddr == `OCS_UNLOCK) unl <= pwdata == PASS_KEY;
      if (ok && paddr == `OCS_CTRL) scl <= pwdata[1];
      fcnt <= (wr || !force_active) ? 0 : fcnt + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_trip_start;
    (stage_trip & ~stage_start) == '0;
  endproperty
  a_trip_start: assert property (p_trip_start) else $error("trip without start");
  property p_trip_after;
    $rose(stage_trip[0]) && !$past(force_active) |-> $past(stage_start[0]);
  endproperty
  a_trip_after: assert property (p_trip_after) else $error("trip skipped start");
  property p_block;
    (stage_block[1] && !force_active) [*3] |-> !stage_start[1];
  endproperty
  a_block: assert property (p_block) else $error("blocked stage started");
  property p_zero;
    (zero && !force_active) [*3] |-> stage_start == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("start without current");
  property p_locked;
    wr && !unl && (paddr == `OCS_CTRL || paddr == `OCS_SCALE) |-> pslverr;
  endproperty
  a_locked: assert property (p_locked) else $error("locked write accepted");
  property p_force_gate;
    wr && paddr == `OCS_FORCE_STATE && !force_active |-> pslverr;
  endproperty
  a_force_gate: assert property (p_force_gate) else $error("forced state without force");
  property p_force_timeout;
    fcnt <= LIM;
  endproperty
  a_force_timeout: assert property (p_force_timeout) else $error("force never timed out");
  property p_scale_group;
    ok && paddr == `OCS_CTRL && pwdata[1] |-> ##[1:3] active_group_index == 2'h1;
  endproperty
  a_scale_group: assert property (p_scale_group) else $error("scaling kept group");
  property p_scale_hold;
    scl && $past(scl) && $past(scl, 2) |-> active_group_index == 2'h1;
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("group left two");
  property p_grp2_owned;
    wr && scl && paddr >= 12'h120 && paddr <= 12'h13c |-> pslverr;
  endproperty
  a_grp2_owned: assert property (p_grp2_owned) else $error("group two write accepted");
  c_trip: cover property (stage_trip[0]);
  c_scale: cover property (scl && active_group_index == 2'h1);
  c_force_end: cover property ($fell(force_active));
endmodule // ocs_checker
bind ocs_top ocs_checker #(.NS(NS), .CUR_W(CUR_W), .MS_CYC(MS_CYC), .FORCE_MS(FORCE_MS),
  .PASS_KEY(PASS_KEY)) chk_i (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .phase_a_current(phase_a_current), .phase_b_current(phase_b_current),
  .phase_c_current(phase_c_current), .stage_block(stage_block), .stage_start(stage_start),
  .stage_trip(stage_trip), .active_group_index(active_group_index),
  .force_active(force_active));
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ocs_defs.vh"
module tb;
  localparam logic [31:0] KEY = 32'h1357_2468;  // Arbitrary key
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ef = 1'b0;
  logic [15:0] ia = '0, ib = '0, ic = '0;
  logic [2:0] blk = 3'b110;
  logic [7:0] din = '0, vin = '0, lamp = '0, vout = '0;
  logic [31:0] rtc_d = 32'h0123_0456, rtc_t = 32'h0789_0abc;
  logic psel, penable, pwrite, pready, pslverr, frc, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] st_s, st_t;
  logic [1:0] grp;
  logic [3:0] pat [7] = '{4'h9, 4'ha, 4'hc, 4'h3, 4'h6, 4'h5, 4'h7};
  int miscompares = 0;
  int total_checks = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  ocs_top #(.MS_CYC(10), .FORCE_MS(20), .PASS_KEY(KEY)) dut (.ref_clk(ref_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_a_current(ia),
    .phase_b_current(ib), .phase_c_current(ic), .earth_fault(ef), .stage_block(blk),
    .digital_in(din), .virtual_input_n(vin), .indicator_lamp_n(lamp),
    .virtual_output_n(vout), .rtc_date(rtc_d), .rtc_time_ms(rtc_t), .stage_start(st_s),
    .stage_trip(st_t), .active_group_index(grp), .force_active(frc));
  ocs_apb_host host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    logic to;
    host.xfer(w, a, d, q, err, to);
    if (to) begin
      miscompares++;
      print_verdict();
    end
    chk("slave error", err, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    acc(1'b0, a, 32'h0, 1'b0);
    chk(nm, q, x);
  endtask
  // Bounded wait on the trip output of stage 0 or on the force flag
  task automatic wait_on(input bit f, input logic v, output int c);
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while ((f ? frc : st_t[0]) !== v && c < 3000);
    if (c >= 3000) begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic cur(input logic [3:0] p);
    @(posedge ref_clk);
    ia <= p[0] ? 16'h300 : 16'h0;
    ib <= p[1] ? 16'h280 : 16'h0;
    ic <= p[2] ? 16'h200 : 16'h0;
    ef <= p[3];
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`OCS_SCALE, 32'h64, "scale reset");
    rd(`OCS_STATUS, 32'h5000, "status");
    wr(`OCS_CTRL, 32'h8, 1'b1);
    acc(1'b0, 12'hffc, 32'h0, 1'b1);
    chk("unmapped data", q, 32'h0);
    wr(`OCS_UNLOCK, KEY, 1'b0);
    rd(`OCS_UNLOCK, 32'h1, "unlocked");
    // Below pick-up, held past two full averaging windows
    ia <= 16'h80;
    repeat (20010) @(posedge ref_clk);
    rd(`OCS_LOAD, 32'h80, "load average");
    ia <= 16'h0;
    for (int k = 0; k < 5; k++) begin
      @(posedge ref_clk);
      din <= (k < 2) ? 8'h20 : 8'hdf;
      vin <= (k == 0 || k == 2) ? 8'h20 : 8'hdf;
      lamp <= (k == 0 || k == 3) ? 8'h20 : 8'hdf;
      vout <= (k == 0 || k == 4) ? 8'h20 : 8'hdf;
      wr(`OCS_CTRL, 32'ha38 | (32'(k) << 6), 1'b0);
      repeat (3) @(negedge ref_clk);
      chk("source group", grp, (k == 0) ? 2'h2 : 2'h3);
    end
    wr(`OCS_CTRL, 32'h0, 1'b0);
    wr(`OCS_SET_BASE + 12'h4, 32'h3, 1'b0);
    for (int k = 0; k < 7; k++) begin
      cur(pat[k]);
      wait_on(1'b0, 1'b1, n);
      chk("trip delay", n >= 20 && n <= 36, 1'b1);
      chk("start level", st_s[0], 1'b1);
      rd(`OCS_LMAX, pat[k][0] ? 32'h300 : pat[k][1] ? 32'h280 : 32'h200, "largest");
      rd(`OCS_LOG_BASE + 12'h8, 32'(k + 1), "fault type");
      cur(4'h0);
      wait_on(1'b0, 1'b0, n);
    end
    rd(`OCS_LOG_BASE, rtc_d, "log date");
    rd(`OCS_LOG_BASE + 12'h4, rtc_t, "log time");
    rd(`OCS_LOG_BASE + 12'hc, 32'h300, "log current");
    rd(`OCS_LOG_BASE + 12'h14, 32'h64, "log delay");
    rd(`OCS_LOG_BASE + 12'h18, 32'h1, "log group");
    rd(`OCS_LOG_BASE + 12'hc8, 32'h1, "oldest type");
    rd(`OCS_CNT_BASE, 32'h7, "start count");
    rd(`OCS_CNT_BASE + 12'h4, 32'h7, "trip count");
    wr(`OCS_CNT_CLR, 32'h101, 1'b0);
    rd(`OCS_CNT_BASE, 32'h0, "start cleared");
    rd(`OCS_CNT_BASE + 12'h4, 32'h0, "trip cleared");
    wr(`OCS_FORCE_STATE, 32'h3, 1'b1);
    wr(`OCS_CTRL, 32'h1, 1'b0);
    wr(`OCS_FORCE_STATE, 32'h3, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk("forced trip", st_t[0], 1'b1);
    rd(`OCS_STATUS, 32'h5cf0, "forced status");
    wait_on(1'b1, 1'b0, n);
    chk("force timeout", n >= 175 && n <= 215, 1'b1);
    repeat (2) @(negedge ref_clk);
    chk("trip released", st_t[0], 1'b0);
    wr(`OCS_SCALE, 32'h5, 1'b0);
    rd(`OCS_SCALE, 32'ha, "scale low");
    wr(`OCS_SCALE, 32'hfa, 1'b0);
    rd(`OCS_SCALE, 32'hc8, "scale high");
    wr(`OCS_SCALE, 32'h32, 1'b0);
    wr(`OCS_SET_BASE, 32'h300, 1'b0);
    wr(`OCS_CTRL, 32'he, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk("scaled group", grp, 2'h1);
    rd(`OCS_SET_BASE + 12'h20, 32'h180, "scaled pickup");
    rd(`OCS_SET_BASE + 12'h24, 32'h3, "copied delay");
    wr(`OCS_SET_BASE + 12'h20, 32'h5, 1'b1);
    rd(`OCS_PRIM_BASE, 32'h180, "primary");
    wr(`OCS_CT_RATIO, 32'h200, 1'b0);
    rd(`OCS_PRIM_BASE, 32'h300, "primary ct");
    chk("held group", grp, 2'h1);
    wr(`OCS_CTRL, 32'hc, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk("manual group", grp, 2'h3);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
